// ===== src/pma_mgmt_regs.sv
// Purpose: PHY management registers, ownership and per-port link status.
// Assumes: Both register masters are synchronous to clk; reads are
//          answered one cycle after the strobe.
// Notes: Frames run in the mgmt_clk domain through a toggle handshake.
`timescale 1ns/1ps
`default_nettype none
module pma_mgmt_regs #(
    parameter int NPORTS = 4,
    parameter logic [4:0] PORT_PHY_BASE = 5'h00
) (
    // Register clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Fieldbus-side register port
    input wire logic [15:0] fb_addr,
    input wire logic fb_wr,
    input wire logic fb_rd,
    input wire logic [7:0] fb_wdata,
    output logic [7:0] fb_rdata_r,
    input wire logic fb_sof,
    // Host-side register port
    input wire logic [15:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_r,
    input wire logic host_acc_end,
    // Link clock and management pins
    input wire logic mgmt_clk,
    output logic mdc,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic mdio_i,
    // Port link control
    output logic [NPORTS-1:0] link_inhibit_r
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (NPORTS < 1 || NPORTS > pma_pkg::MAX_PORTS) begin : g_bad_ports
        $error("NPORTS must be 1 to 4");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic own_r;
    logic force_r;
    logic claim_r;
    logic wen_r;
    logic wen_host_r;
    logic [1:0] cmd_r;
    logic busy_r;
    logic rd_err_r;
    logic cmd_err_r;
    logic [4:0] phy_r;
    logic [4:0] reg_r;
    logic [15:0] data_r;
    logic req_tgl_r;
    logic done_seen_r;
    logic [NPORTS-1:0] st_link_r;
    logic [NPORTS-1:0] st_full_r;
    logic [NPORTS-1:0] st_rderr_r;
    logic [NPORTS-1:0] st_lperr_r;
    logic [NPORTS-1:0] st_cfg_r;
    logic done_tgl;
    logic done_s;
    logic [15:0] eng_rdata;
    logic eng_err;

    // ------------------------------------------------------------
    // Ownership and owner write strobe
    // ------------------------------------------------------------
    // The owner alone writes the management registers.
    wire logic host_owns = own_r;
    wire logic mw = host_owns ? host_wr : fb_wr;
    wire logic [15:0] ma = host_owns ? host_addr : fb_addr;
    wire logic [7:0] md = host_owns ? host_wdata : fb_wdata;
    wire logic w_ctl_lo = mw && ma == pma_pkg::ADDR_CTL_LO && !busy_r;
    wire logic w_ctl_hi = mw && ma == pma_pkg::ADDR_CTL_HI && !busy_r;
    wire logic w_phy = mw && ma == pma_pkg::ADDR_PHY_SEL && !busy_r;
    wire logic w_reg = mw && ma == pma_pkg::ADDR_REG_SEL && !busy_r;
    wire logic w_dlo = mw && ma == pma_pkg::ADDR_DATA_LO && !busy_r;
    wire logic w_dhi = mw && ma == pma_pkg::ADDR_DATA_HI && !busy_r;
    wire logic [15:0] st_off = ma - pma_pkg::ADDR_PORT_STAT;
    wire logic w_stat = mw && ma >= pma_pkg::ADDR_PORT_STAT
        && st_off < 16'(NPORTS);
    // The force bit belongs to the fieldbus side regardless of owner; the claim bit only while the host does not own.
    wire logic w_claim = fb_wr && fb_addr == pma_pkg::ADDR_FB_CLAIM && !own_r;
    wire logic w_force = fb_wr && fb_addr == pma_pkg::ADDR_HOST_CLAIM;
    wire logic w_own = host_wr && host_addr == pma_pkg::ADDR_HOST_CLAIM
        && !claim_r && !force_r;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire logic [1:0] new_cmd = md[1:0];
    wire logic wen_eff = wen_r || host_owns;
    wire logic cmd_ok = new_cmd == pma_pkg::CMD_READ
        || (new_cmd == pma_pkg::CMD_WRITE && wen_eff);
    wire logic start = w_ctl_hi && cmd_ok;
    wire logic bad_cmd = w_ctl_hi && !cmd_ok && new_cmd != pma_pkg::CMD_IDLE;
    wire logic clr_cmd = w_ctl_hi && new_cmd == pma_pkg::CMD_IDLE;
    wire logic done_evt = done_s != done_seen_r;
    wire logic was_read = cmd_r == pma_pkg::CMD_READ;
    wire logic bmsr_read = done_evt && was_read && reg_r == pma_pkg::BMSR_ADDR;

    // ------------------------------------------------------------
    // Ownership registers
    // ------------------------------------------------------------
    // Force wins over a host claim in the same cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            own_r <= 1'b0;
            force_r <= 1'b0;
            claim_r <= 1'b0;
        end else begin
            if (w_claim) claim_r <= fb_wdata[0];
            if (w_force) force_r <= fb_wdata[1];
            if (w_force && fb_wdata[1]) begin
                own_r <= 1'b0;
            end else if (w_own) begin
                own_r <= host_wdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Control, address and data registers
    // ------------------------------------------------------------
    // Write enable is cleared by frame start, or by host access end if the host set it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wen_r <= 1'b0;
            wen_host_r <= 1'b0;
        end else if (w_ctl_lo) begin
            wen_r <= md[0];
            wen_host_r <= host_owns;
        end else if (fb_sof || (wen_host_r && host_acc_end)) begin
            wen_r <= 1'b0;
        end
    end

    // Command, busy and errors; completion clears the command.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_r <= pma_pkg::CMD_IDLE;
            busy_r <= 1'b0;
            rd_err_r <= 1'b0;
            cmd_err_r <= 1'b0;
            req_tgl_r <= 1'b0;
            done_seen_r <= 1'b0;
        end else begin
            done_seen_r <= done_s;
            if (start) begin
                cmd_r <= new_cmd;
                busy_r <= 1'b1;
                req_tgl_r <= ~req_tgl_r;
                cmd_err_r <= 1'b0;
                rd_err_r <= 1'b0;
            end else if (done_evt) begin
                cmd_r <= pma_pkg::CMD_IDLE;
                busy_r <= 1'b0;
                rd_err_r <= was_read && eng_err;
            end else if (w_ctl_hi) begin
                cmd_err_r <= bad_cmd;
                rd_err_r <= 1'b0;
            end
        end
    end

    // Address and data holding registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phy_r <= '0;
            reg_r <= '0;
            data_r <= '0;
        end else begin
            if (w_phy) phy_r <= md[4:0];
            if (w_reg) reg_r <= md[4:0];
            if (w_dlo) data_r[7:0] <= md;
            if (w_dhi) data_r[15:8] <= md;
            if (done_evt && was_read) data_r <= eng_rdata;
        end
    end

    // ------------------------------------------------------------
    // Per-port status
    // ------------------------------------------------------------
    // Sticky bits: a setting event beats a clearing write.
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        wire logic hit = phy_r == PORT_PHY_BASE + 5'(p);
        wire logic full = eng_rdata[pma_pkg::BMSR_LINK]
            && eng_rdata[pma_pkg::BMSR_100FD] && eng_rdata[pma_pkg::BMSR_ANDONE];
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                st_link_r[p] <= 1'b0;
                st_full_r[p] <= 1'b0;
                st_lperr_r[p] <= 1'b0;
                st_rderr_r[p] <= 1'b0;
                st_cfg_r[p] <= 1'b0;
                link_inhibit_r[p] <= 1'b0;
            end else begin
                if (bmsr_read && hit && !eng_err) begin
                    st_link_r[p] <= eng_rdata[pma_pkg::BMSR_LINK];
                    st_full_r[p] <= full;
                    st_lperr_r[p] <= eng_rdata[pma_pkg::BMSR_RFAULT];
                    link_inhibit_r[p] <= eng_rdata[pma_pkg::BMSR_LINK] && !full;
                end
                if (done_evt && was_read && hit && eng_err) begin
                    st_rderr_r[p] <= 1'b1;
                end else if (w_stat) begin
                    st_rderr_r[p] <= 1'b0;
                end
                if (done_evt && !was_read && hit) begin
                    st_cfg_r[p] <= 1'b1;
                end else if (w_stat) begin
                    st_cfg_r[p] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read mux shared by both masters; data reads zero while busy.
    function automatic logic [7:0] rd_mux(input logic [15:0] a);
        logic [15:0] off;
        logic [7:0] v;
        off = a - pma_pkg::ADDR_PORT_STAT;
        v = 8'h00;
        case (a)
            pma_pkg::ADDR_CTL_LO: v = {7'h00, wen_eff};
            pma_pkg::ADDR_CTL_HI: v = {busy_r, cmd_err_r, rd_err_r, 3'h0, cmd_r};
            pma_pkg::ADDR_PHY_SEL: v = {3'h0, phy_r};
            pma_pkg::ADDR_REG_SEL: v = {3'h0, reg_r};
            pma_pkg::ADDR_DATA_LO: v = busy_r ? 8'h00 : data_r[7:0];
            pma_pkg::ADDR_DATA_HI: v = busy_r ? 8'h00 : data_r[15:8];
            pma_pkg::ADDR_FB_CLAIM: v = {7'h00, claim_r};
            pma_pkg::ADDR_HOST_CLAIM: v = {6'h00, force_r, own_r};
            default: begin
                if (a >= pma_pkg::ADDR_PORT_STAT && off < 16'(NPORTS)) begin
                    v = {2'h0, st_cfg_r[off[1:0]], st_lperr_r[off[1:0]],
                        st_rderr_r[off[1:0]], link_inhibit_r[off[1:0]],
                        st_full_r[off[1:0]], st_link_r[off[1:0]]};
                end
            end
        endcase
        return v;
    endfunction

    // Read data is held until the next read strobe.
    // The mux is called at the edge, so it always sees the live state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fb_rdata_r <= 8'h00;
            host_rdata_r <= 8'h00;
        end else begin
            if (fb_rd) fb_rdata_r <= rd_mux(fb_addr);
            if (host_rd) host_rdata_r <= rd_mux(host_addr);
        end
    end

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    // Fields are quasi-static while busy, so only the toggles cross.
    pma_sync2 #(.W(1)) u_done_sync (
        .clk(clk),
        .rstn(rstn),
        .d(done_tgl),
        .q(done_s)
    );

    pma_mdio_engine u_engine (
        .mgmt_clk(mgmt_clk),
        .rstn(rstn),
        .req_tgl(req_tgl_r),
        .op_write(cmd_r == pma_pkg::CMD_WRITE),
        .phy(phy_r),
        .regn(reg_r),
        .wdata(data_r),
        .done_tgl_r(done_tgl),
        .rdata_r(eng_rdata),
        .rd_err_r(eng_err),
        .mdc_r(mdc),
        .mdio_o_r(mdio_o),
        .mdio_oe_r(mdio_oe),
        .mdio_i(mdio_i)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    phy_hold_a: assert property (busy_r && mw && ma == pma_pkg::ADDR_PHY_SEL
        |=> $stable(phy_r)) else $error("PHY select changed while busy");
    data_rd_a: assert property (busy_r && fb_rd && fb_addr == pma_pkg::ADDR_DATA_LO
        |=> fb_rdata_r == 8'h00) else $error("data readable while busy");
    cmd_done_a: assert property (busy_r && done_evt
        |=> cmd_r == pma_pkg::CMD_IDLE && !busy_r) else $error("command not cleared");
    wen_sof_a: assert property (fb_sof && !w_ctl_lo |=> !wen_r)
        else $error("write enable survived frame start");
    claim_lock_a: assert property (own_r && fb_wr && fb_addr == pma_pkg::ADDR_FB_CLAIM
        |=> $stable(claim_r)) else $error("claim written while host owns");
    force_own_a: assert property (w_force && fb_wdata[1] |=> !own_r)
        else $error("force did not drop ownership");
    own_gate_a: assert property ((claim_r || force_r) && !w_force
        |=> $stable(own_r)) else $error("ownership changed while blocked");
    cmd_err_a: assert property (w_ctl_hi && md[1:0] == 2'h3 |=> cmd_err_r && !busy_r)
        else $error("invalid command not flagged");
    stat_clr_a: assert property (w_stat && !done_evt
        |=> st_rderr_r == '0 && st_cfg_r == '0)
        else $error("status write did not clear sticky bits");
    busy_start_a: assert property (start |=> busy_r [*2])
        else $error("busy not raised for command");
    cmd_clr_a: assert property (clr_cmd |=> !cmd_err_r && !rd_err_r)
        else $error("idle command left error bits set");

    read_cov_c: cover property (start && new_cmd == pma_pkg::CMD_READ ##[1:1000] done_evt);
    write_cov_c: cover property (start && new_cmd == pma_pkg::CMD_WRITE);
    host_cov_c: cover property (w_own && host_wdata[0]);
    rderr_cov_c: cover property (done_evt && eng_err);
endmodule : pma_mgmt_regs
`default_nettype wire

// ===== src/pma_pkg.sv
// Purpose: Shared constants for the PHY management register block.
// Assumes: Byte-wide register ports on both register masters.
// Notes: Addresses are byte addresses of the register map.
package pma_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_CTL_LO = 16'h0510;
    localparam logic [15:0] ADDR_CTL_HI = 16'h0511;
    localparam logic [15:0] ADDR_PHY_SEL = 16'h0512;
    localparam logic [15:0] ADDR_REG_SEL = 16'h0513;
    localparam logic [15:0] ADDR_DATA_LO = 16'h0514;
    localparam logic [15:0] ADDR_DATA_HI = 16'h0515;
    localparam logic [15:0] ADDR_FB_CLAIM = 16'h0516;
    localparam logic [15:0] ADDR_HOST_CLAIM = 16'h0517;
    localparam logic [15:0] ADDR_PORT_STAT = 16'h0518;
    localparam int MAX_PORTS = 4;
    // ------------------------------------------------------------
    // Command codes and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] CMD_IDLE = 2'h0;
    localparam logic [1:0] CMD_READ = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [4:0] BMSR_ADDR = 5'h01;
    localparam int BMSR_LINK = 2;
    localparam int BMSR_RFAULT = 4;
    localparam int BMSR_ANDONE = 5;
    localparam int BMSR_100FD = 14;
    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
    localparam logic [1:0] SOF_BITS = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] TA_WRITE = 2'h2;
    localparam logic [6:0] TA_FIRST = 7'h2E;
    localparam logic [6:0] TA_SECOND = 7'h2F;
    localparam logic [6:0] LAST_BIT = 7'h3F;
endpackage : pma_pkg

// ===== src/pma_sync2.sv
// Purpose: Two-stage synchroniser for levels entering a clock domain.
// Assumes: Inputs change slowly relative to the destination clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pma_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Two flops in a row; q alone is safe to read.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : pma_sync2
`default_nettype wire

// ===== src/pma_mdio_engine.sv
// Purpose: Serial management frame engine on the link clock.
// Assumes: Request fields stay stable from the request toggle to done.
// Notes: The management clock output runs at half the link clock.
`timescale 1ns/1ps
`default_nettype none
module pma_mdio_engine (
    // Link clock and reset
    input wire logic mgmt_clk,
    input wire logic rstn,
    // Request from the register domain
    input wire logic req_tgl,
    input wire logic op_write,
    input wire logic [4:0] phy,
    input wire logic [4:0] regn,
    input wire logic [15:0] wdata,
    // Answer to the register domain
    output logic done_tgl_r,
    output logic [15:0] rdata_r,
    output logic rd_err_r,
    // Management pins
    output logic mdc_r,
    output logic mdio_o_r,
    output logic mdio_oe_r,
    input wire logic mdio_i
);
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} pma_eng_t;
    pma_eng_t st_r;
    logic [63:0] sh_r;
    logic [6:0] cnt_r;
    logic ack_r;
    logic wr_r;
    logic req_s;
    logic mdio_s;
    wire logic new_req = (st_r == ST_IDLE) && (req_s != ack_r);
    wire logic at_end = (cnt_r == pma_pkg::LAST_BIT);
    wire logic drive_nxt = wr_r || (cnt_r + 7'h01 < pma_pkg::TA_FIRST);
    wire logic [63:0] frame = {pma_pkg::PREAMBLE, pma_pkg::SOF_BITS,
        op_write ? pma_pkg::OP_WRITE : pma_pkg::OP_READ, phy, regn,
        pma_pkg::TA_WRITE, op_write ? wdata : 16'h0000};

    // Request toggle and the data pin both cross into this domain.
    pma_sync2 #(.W(2)) u_sync (
        .clk(mgmt_clk),
        .rstn(rstn),
        .d({req_tgl, mdio_i}),
        .q({req_s, mdio_s})
    );

    // Data changes while the clock is low and is sampled when it falls.
    // Sampling lags by the synchroniser, so slow PHYs are tolerated.
    always_ff @(posedge mgmt_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= ST_IDLE;
            sh_r <= '0;
            cnt_r <= '0;
            ack_r <= 1'b0;
            wr_r <= 1'b0;
            done_tgl_r <= 1'b0;
            rdata_r <= '0;
            rd_err_r <= 1'b0;
            mdc_r <= 1'b0;
            mdio_o_r <= 1'b1;
            mdio_oe_r <= 1'b0;
        end else if (new_req) begin
            st_r <= ST_RUN;
            ack_r <= req_s;
            wr_r <= op_write;
            sh_r <= frame;
            cnt_r <= '0;
            rd_err_r <= 1'b0;
            mdc_r <= 1'b0;
            mdio_o_r <= frame[63];
            mdio_oe_r <= 1'b1;
        end else if (st_r == ST_RUN) begin
            mdc_r <= ~mdc_r;
            if (mdc_r) begin
                if (!wr_r && cnt_r == pma_pkg::TA_SECOND && mdio_s) begin
                    rd_err_r <= 1'b1;
                end
                if (!wr_r && cnt_r > pma_pkg::TA_SECOND) begin
                    rdata_r <= {rdata_r[14:0], mdio_s};
                end
                if (at_end) begin
                    st_r <= ST_IDLE;
                    done_tgl_r <= ~done_tgl_r;
                    mdio_oe_r <= 1'b0;
                end else begin
                    sh_r <= {sh_r[62:0], 1'b0};
                    cnt_r <= cnt_r + 7'h01;
                    mdio_o_r <= sh_r[62];
                    mdio_oe_r <= drive_nxt;
                end
            end
        end
    end
endmodule : pma_mdio_engine
`default_nettype wire

// ===== verification/pma_phy_model.sv
// Purpose: Behavioural PHY on the serial management pins.
// Assumes: Frames use a 32-bit preamble and the 01 start pattern.
// Notes: Answers only its own address; otherwise the pull-up shows.
`timescale 1ns/1ps
`default_nettype none
module pma_phy_model #(
    parameter logic [4:0] ADDR = 5'h00
) (
    // Management pins
    input wire logic mdc,
    input wire logic mdio,
    output logic oe,
    output logic o
);
    logic [15:0] sh;
    logic [15:0] rf [0:31];
    logic [1:0] op;
    logic [4:0] pa;
    logic [4:0] ra;
    int c = 0;
    // Register 1 reports link, autonegotiation done and 100 full duplex.
    initial begin
        {oe, o, sh} = '0;
        rf[1] = 16'h4024;
    end
    // Bits are taken at the rising clock and our answer changes there too,
    // so the controller finds it settled at the falling clock.
    always @(posedge mdc) begin
        sh = {sh[14:0], mdio};
        if (c == 0) begin
            c = (sh[2:0] == 3'b101) ? 2 : 0;
        end else begin
            if (c == 3) op = sh[1:0];
            if (c == 8) pa = sh[4:0];
            if (c == 13) ra = sh[4:0];
            if (c == 31 && op == 2'b01 && pa == ADDR) rf[ra] = sh;
            oe = (c >= 14 && c < 31 && op == 2'b10 && pa == ADDR);
            o = (c >= 15 && c < 31) ? rf[ra][30 - c] : 1'b0;
            if (c == 31) sh = '0; // Stale data must not fake a start pattern.
            c = (c == 31) ? 0 : c + 1;
        end
    end
endmodule : pma_phy_model
`default_nettype wire

// ===== verification/pma_mgmt_regs_tb.sv
// Purpose: Self-checking bench for the PHY management register block.
// Assumes: One modelled PHY at address 0; other addresses stay silent.
// Notes: Read data is judged two cycles after the strobe.
`timescale 1ns/1ps
`default_nettype none
module pma_mgmt_regs_tb;
    logic clk = 0, mgmt_clk = 0, rstn = 0, fb_sof = 0, host_acc_end = 0;
    logic fb_wr = 0, fb_rd = 0, host_wr = 0, host_rd = 0, mdc, mdio_o, mdio_oe, p_oe, p_o;
    logic [15:0] fb_addr = '0, host_addr = '0;
    logic [7:0] fb_wdata = '0, host_wdata = '0, fb_rdata_r, host_rdata_r, q;
    logic [3:0] link_inhibit_r;
    int failures = 0, tests_run = 0, cyc = 0;
    // The pin has a pull-up, so a released line reads high.
    wire mdio = mdio_oe ? mdio_o : (p_oe ? p_o : 1'b1);
    pma_mgmt_regs i_pma_mgmt_regs (.clk, .rstn, .fb_addr, .fb_wr, .fb_rd, .fb_wdata,
        .fb_rdata_r, .fb_sof, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata_r,
        .host_acc_end, .mgmt_clk, .mdc, .mdio_o, .mdio_oe, .mdio_i(mdio), .link_inhibit_r);
    pma_phy_model i_pma_phy_model (.mdc, .mdio, .oe(p_oe), .o(p_o));
    // Clocks; the link clock has its own phase.
    initial forever #12.5 clk = ~clk;
    initial begin
        #7;
        forever #80 mgmt_clk = ~mgmt_clk;
    end
    // A hang is cut short well beyond the few frames run here.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // One byte access; the strobe lasts one cycle.
    task automatic acc(input logic h, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        if (h) {host_addr, host_wdata, host_wr, host_rd} = {a, d, w, !w};
        else {fb_addr, fb_wdata, fb_wr, fb_rd} = {a, d, w, !w};
        @(negedge clk);
        {fb_wr, fb_rd, host_wr, host_rd} = '0;
        @(negedge clk);
        q = h ? host_rdata_r : fb_rdata_r;
    endtask : acc
    task automatic chk(input logic h, input logic [15:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        acc(h, 1'b0, a, 8'h00);
        check($sformatf("reg %h", a), {8'h00, q & m}, {8'h00, e});
    endtask : chk
    // Issue a command and poll busy under a bounded count.
    task automatic run(input logic [7:0] c);
        acc(1'b0, 1'b1, 16'h0511, c);
        q = 8'h80;
        for (int i = 0; i < 400 && q[7] !== 1'b0; i++) acc(1'b0, 1'b0, 16'h0511, 8'h00);
        check("busy", {8'h00, q & 8'h80}, 16'h0000);
    endtask : run
    task automatic t_reset();
        for (int i = 0; i < 9; i++) chk(1'b0, 16'h0510 + 16'(i), 8'h00);
    endtask : t_reset
    task automatic t_owner();
        acc(1'b1, 1'b1, 16'h0517, 8'h01);
        chk(1'b1, 16'h0517, 8'h01);
        chk(1'b0, 16'h0510, 8'h01, 8'h01);
        acc(1'b0, 1'b1, 16'h0512, 8'h07);
        acc(1'b0, 1'b1, 16'h0516, 8'h01);
        chk(1'b0, 16'h0512, 8'h00);
        chk(1'b0, 16'h0516, 8'h00);
        acc(1'b0, 1'b1, 16'h0517, 8'h02);
        acc(1'b1, 1'b1, 16'h0517, 8'h01);
        chk(1'b1, 16'h0517, 8'h02);
        acc(1'b0, 1'b1, 16'h0517, 8'h00);
        acc(1'b0, 1'b1, 16'h0516, 8'h01);
        acc(1'b1, 1'b1, 16'h0517, 8'h01);
        chk(1'b1, 16'h0517, 8'h00);
        acc(1'b0, 1'b1, 16'h0516, 8'h00);
        acc(1'b1, 1'b1, 16'h0517, 8'h01);
        acc(1'b1, 1'b1, 16'h0510, 8'h01);
        @(negedge clk) host_acc_end = 1;
        @(negedge clk) host_acc_end = 0;
        acc(1'b1, 1'b1, 16'h0517, 8'h00);
        chk(1'b0, 16'h0510, 8'h00);
    endtask : t_owner
    task automatic t_read();
        acc(1'b0, 1'b1, 16'h0513, 8'hE1);
        chk(1'b0, 16'h0513, 8'h01);
        acc(1'b0, 1'b1, 16'h0514, 8'h5A);
        acc(1'b0, 1'b1, 16'h0511, 8'h01);
        acc(1'b0, 1'b1, 16'h0512, 8'h03);
        chk(1'b0, 16'h0511, 8'h81);
        chk(1'b0, 16'h0514, 8'h00);
        chk(1'b0, 16'h0512, 8'h00);
        run(8'h00);
        chk(1'b0, 16'h0511, 8'h00);
        chk(1'b0, 16'h0514, 8'h24);
        chk(1'b0, 16'h0515, 8'h40);
        chk(1'b0, 16'h0518, 8'h03);
    endtask : t_read
    task automatic t_write();
        acc(1'b0, 1'b1, 16'h0510, 8'h01);
        @(negedge clk) fb_sof = 1;
        @(negedge clk) fb_sof = 0;
        chk(1'b0, 16'h0510, 8'h00);
        run(8'h02);
        chk(1'b0, 16'h0511, 8'h40, 8'h40);
        run(8'h03);
        chk(1'b0, 16'h0511, 8'h40, 8'h40);
        run(8'h00);
        chk(1'b0, 16'h0511, 8'h00);
        acc(1'b0, 1'b1, 16'h0510, 8'h01);
        acc(1'b0, 1'b1, 16'h0514, 8'h14);
        acc(1'b0, 1'b1, 16'h0515, 8'h00);
        run(8'h02);
        run(8'h01);
        chk(1'b0, 16'h0518, 8'h35);
        check("inhibit", 16'(link_inhibit_r), 16'h0001);
        acc(1'b0, 1'b1, 16'h0519, 8'h00);
        chk(1'b0, 16'h0518, 8'h15);
    endtask : t_write
    task automatic t_rderr();
        acc(1'b0, 1'b1, 16'h0512, 8'h03);
        run(8'h01);
        chk(1'b0, 16'h051B, 8'h08, 8'h08);
        acc(1'b0, 1'b1, 16'h0518, 8'h00);
        chk(1'b0, 16'h051B, 8'h00, 8'h08);
    endtask : t_rderr
    // Main sequence.
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1;
        t_reset();
        t_owner();
        t_read();
        t_write();
        t_rderr();
        wrap_up();
    end
endmodule : pma_mgmt_regs_tb
`default_nettype wire
